/* core/lsa_align_chk.sv */
// combinational operand alignment checker
`timescale 1ns/1ps
module lsa_align_chk (
	// access description
	input  wire logic [lsa_pkg::ADDR_W-1:0] i_addr,
	input  wire lsa_pkg::lsa_size_t         i_size,
	// result
	output logic                            o_misaligned
);
	// a width of 2^n bytes needs the low n address bits clear
	always_comb begin
		unique case (i_size)
			lsa_pkg::LSA_SZ_BYTE:  o_misaligned = 1'b0;
			lsa_pkg::LSA_SZ_HALF:  o_misaligned = i_addr[0];
			lsa_pkg::LSA_SZ_WORD:  o_misaligned = |i_addr[1:0];
			lsa_pkg::LSA_SZ_DWORD: o_misaligned = |i_addr[2:0];
		endcase
	end
endmodule // lsa_align_chk

/* core/lsa_core.sv */
// load/store operand addressing, alignment, register files and in-order retire
// Operation
// - memory bytes numbered from zero, number is address
// - byte/half/word/double sizes fixed by opcode
// - operand address is its lowest byte address
// - misaligned when address not multiple of width
// - word fetch; unaligned fetch costs one extra cycle
// - 32 general registers, byte/half/word transfers
// - 32 float registers, word/double transfers
// - float loads written in double format
// - integer ops on word general registers
// - arithmetic never touches memory
// - results retire strictly in program order
`timescale 1ns/1ps
module lsa_core (
	// clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_srst,
	// instruction fetch request
	input  wire logic                          i_fetch_req,
	input  wire logic [lsa_pkg::ADDR_W-1:0]    i_fetch_pc,
	output logic                               o_fetch_vld,
	output logic [lsa_pkg::ADDR_W-1:0]         o_fetch_addr,
	output logic                               o_fetch_busy,
	// issue of one instruction
	input  wire logic                          i_issue_vld,
	input  wire lsa_pkg::lsa_op_t              i_issue_op,
	input  wire logic [lsa_pkg::TAG_W-1:0]     i_issue_tag,
	input  wire logic [lsa_pkg::REG_IDX_W-1:0] i_issue_base,
	input  wire logic [lsa_pkg::ADDR_W-1:0]    i_issue_disp,
	input  wire logic [lsa_pkg::REG_IDX_W-1:0] i_issue_rd,
	input  wire logic [lsa_pkg::REG_IDX_W-1:0] i_issue_rs,
	input  wire logic [lsa_pkg::WORD_W-1:0]    i_alu_result,
	// memory request toward the memory subsystem
	output logic                               o_mem_vld,
	output logic                               o_mem_we,
	output logic [lsa_pkg::ADDR_W-1:0]         o_mem_addr,
	output lsa_pkg::lsa_size_t                 o_mem_size,
	output logic [lsa_pkg::DWORD_W-1:0]        o_mem_wdata,
	output logic                               o_misaligned,
	// load data back from memory (any order, tagged)
	input  wire logic                          i_ld_vld,
	input  wire logic [lsa_pkg::TAG_W-1:0]     i_ld_tag,
	input  wire logic [lsa_pkg::DWORD_W-1:0]   i_ld_data,
	// retire port, program order
	output logic                               o_ret_vld,
	output logic [lsa_pkg::TAG_W-1:0]          o_ret_tag,
	output logic                               o_ret_float,
	output logic [lsa_pkg::REG_IDX_W-1:0]      o_ret_rd,
	output logic [lsa_pkg::DWORD_W-1:0]        o_ret_data
);
	// ------------------------------------------------------------
	// register files
	// ------------------------------------------------------------
	logic [lsa_pkg::WORD_W-1:0]  general_register_file [lsa_pkg::REG_CNT];
	logic [lsa_pkg::DWORD_W-1:0] float_register_file [lsa_pkg::REG_CNT];

	// ------------------------------------------------------------
	// decode: size and class come from the opcode alone
	// ------------------------------------------------------------
	lsa_pkg::lsa_size_t size_w;
	logic               is_mem_w;
	logic               is_st_w;
	logic               is_fp_w;
	always_comb begin
		size_w   = lsa_pkg::LSA_SZ_WORD;
		is_mem_w = 1'b1;
		is_st_w  = 1'b0;
		is_fp_w  = 1'b0;
		unique case (i_issue_op)
			lsa_pkg::LSA_OP_LBZ:  size_w = lsa_pkg::LSA_SZ_BYTE;
			lsa_pkg::LSA_OP_LHZ:  size_w = lsa_pkg::LSA_SZ_HALF;
			lsa_pkg::LSA_OP_LWZ:  size_w = lsa_pkg::LSA_SZ_WORD;
			lsa_pkg::LSA_OP_STB: begin
				size_w  = lsa_pkg::LSA_SZ_BYTE;
				is_st_w = 1'b1;
			end
			lsa_pkg::LSA_OP_STH: begin
				size_w  = lsa_pkg::LSA_SZ_HALF;
				is_st_w = 1'b1;
			end
			lsa_pkg::LSA_OP_STW:  is_st_w = 1'b1;
			lsa_pkg::LSA_OP_LFS:  is_fp_w = 1'b1;
			lsa_pkg::LSA_OP_LFD: begin
				size_w  = lsa_pkg::LSA_SZ_DWORD;
				is_fp_w = 1'b1;
			end
			lsa_pkg::LSA_OP_STFS: begin
				is_fp_w = 1'b1;
				is_st_w = 1'b1;
			end
			lsa_pkg::LSA_OP_STFD: begin
				size_w  = lsa_pkg::LSA_SZ_DWORD;
				is_fp_w = 1'b1;
				is_st_w = 1'b1;
			end
			default: is_mem_w = 1'b0; // alu and none stay off the memory port
		endcase
	end

	// ------------------------------------------------------------
	// effective address and alignment
	// ------------------------------------------------------------
	logic [lsa_pkg::ADDR_W-1:0] ea_w;
	logic                       mis_w;
	// plain byte address: base plus displacement, no scaling
	assign ea_w = general_register_file[i_issue_base] + i_issue_disp;

	lsa_align_chk u_align (
		.i_addr       (ea_w),
		.i_size       (size_w),
		.o_misaligned (mis_w)
	);

	// store data: word from a general register, float store narrows or passes
	logic [lsa_pkg::DWORD_W-1:0] st_data_w;
	always_comb begin
		st_data_w = {{(lsa_pkg::DWORD_W-lsa_pkg::WORD_W){1'b0}}, general_register_file[i_issue_rs]};
		if (is_fp_w && size_w == lsa_pkg::LSA_SZ_DWORD) begin
			st_data_w = float_register_file[i_issue_rs];
		end else if (is_fp_w) begin
			// simple truncating narrow: sign, top exponent bit and low seven exponent bits, top fraction bits
			st_data_w = {32'h0000_0000, float_register_file[i_issue_rs][63],
				float_register_file[i_issue_rs][62], float_register_file[i_issue_rs][58:29]};
		end
	end

	// memory request registered; flag rides in the same cycle as the address
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_mem_vld    <= 1'b0;
			o_mem_we     <= 1'b0;
			o_mem_addr   <= '0;
			o_mem_size   <= lsa_pkg::LSA_SZ_BYTE;
			o_mem_wdata  <= '0;
			o_misaligned <= 1'b0;
		end else begin
			o_mem_vld    <= i_issue_vld && is_mem_w;
			o_mem_we     <= i_issue_vld && is_mem_w && is_st_w;
			o_mem_addr   <= ea_w;
			o_mem_size   <= size_w;
			o_mem_wdata  <= st_data_w;
			o_misaligned <= i_issue_vld && is_mem_w && mis_w;
		end
	end

	// ------------------------------------------------------------
	// instruction fetch: word aligned, penalty when not
	// ------------------------------------------------------------
	logic [1:0] fetch_wait_q;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_fetch_vld  <= 1'b0;
			o_fetch_addr <= '0;
			o_fetch_busy <= 1'b0;
			fetch_wait_q <= 2'h0;
		end else if (fetch_wait_q != 2'h0) begin
			fetch_wait_q <= fetch_wait_q - 2'h1;
			o_fetch_vld  <= (fetch_wait_q == 2'h1);
			o_fetch_busy <= (fetch_wait_q != 2'h1);
		end else if (i_fetch_req) begin
			o_fetch_addr <= {i_fetch_pc[lsa_pkg::ADDR_W-1:2], lsa_pkg::FETCH_ALIGN};
			if (i_fetch_pc[1:0] != lsa_pkg::FETCH_ALIGN) begin
				fetch_wait_q <= lsa_pkg::FETCH_PENALTY; // extra cycle for unaligned pc
				o_fetch_vld  <= 1'b0;
				o_fetch_busy <= 1'b1;
			end else begin
				o_fetch_vld  <= 1'b1;
				o_fetch_busy <= 1'b0;
			end
		end else begin
			o_fetch_vld  <= 1'b0;
			o_fetch_busy <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// single to double widening for float loads
	// ------------------------------------------------------------
	function automatic logic [lsa_pkg::DWORD_W-1:0] widen_sp(input logic [lsa_pkg::WORD_W-1:0] s);
		logic [lsa_pkg::SP_EXP_W-1:0] e;
		logic [lsa_pkg::DP_EXP_W-1:0] de;
		e  = s[30:23];
		de = {3'h0, e} + lsa_pkg::DP_EXP_BIAS_ADJ;
		// denormal singles are flushed to signed zero, a known limitation
		if (e == lsa_pkg::SP_EXP_ZERO)     de = '0;
		else if (e == lsa_pkg::SP_EXP_MAX) de = lsa_pkg::DP_EXP_MAX;
		if (e == lsa_pkg::SP_EXP_ZERO)
			return {s[31], 63'h0};
		return {s[31], de, s[22:0], 29'h0};
	endfunction

	// ------------------------------------------------------------
	// reorder buffer: entries complete in any order, retire in order
	// ------------------------------------------------------------
	logic                              rob_busy_q  [lsa_pkg::ROB_DEPTH];
	logic                              rob_done_q  [lsa_pkg::ROB_DEPTH];
	logic                              rob_fp_q    [lsa_pkg::ROB_DEPTH];
	logic                              rob_st_q    [lsa_pkg::ROB_DEPTH];
	lsa_pkg::lsa_size_t                rob_sz_q    [lsa_pkg::ROB_DEPTH];
	logic [lsa_pkg::REG_IDX_W-1:0]     rob_rd_q    [lsa_pkg::ROB_DEPTH];
	logic [lsa_pkg::DWORD_W-1:0]       rob_data_q  [lsa_pkg::ROB_DEPTH];
	logic [lsa_pkg::TAG_W-1:0]         head_q;

	// the issuing side allocates tags in program order; head follows them
	logic head_ready_w;
	assign head_ready_w = rob_busy_q[head_q] && rob_done_q[head_q];

	genvar gi;
	generate
		for (gi = 0; gi < lsa_pkg::ROB_DEPTH; gi++) begin : g_rob
			// entry number at tag width; a genvar cannot be part-selected
			localparam logic [lsa_pkg::TAG_W-1:0] ENTRY_TAG = lsa_pkg::TAG_W'(gi);
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					rob_busy_q[gi] <= 1'b0;
					rob_done_q[gi] <= 1'b0;
					rob_fp_q[gi]   <= 1'b0;
					rob_st_q[gi]   <= 1'b0;
					rob_sz_q[gi]   <= lsa_pkg::LSA_SZ_BYTE;
					rob_rd_q[gi]   <= '0;
					rob_data_q[gi] <= '0;
				end else if (i_issue_vld && i_issue_tag == ENTRY_TAG) begin
					rob_busy_q[gi] <= 1'b1;
					// stores and alu results are done at issue; loads wait for data
					rob_done_q[gi] <= !is_mem_w || is_st_w;
					rob_fp_q[gi]   <= is_fp_w;
					rob_st_q[gi]   <= is_st_w || (i_issue_op == lsa_pkg::LSA_OP_NONE);
					rob_sz_q[gi]   <= size_w;
					rob_rd_q[gi]   <= i_issue_rd;
					rob_data_q[gi] <= {32'h0000_0000, i_alu_result};
				end else begin
					if (i_ld_vld && i_ld_tag == ENTRY_TAG) begin
						rob_done_q[gi] <= 1'b1;
						unique case (rob_sz_q[gi])
							lsa_pkg::LSA_SZ_BYTE:  rob_data_q[gi] <= {56'h0, i_ld_data[7:0]};
							lsa_pkg::LSA_SZ_HALF:  rob_data_q[gi] <= {48'h0, i_ld_data[15:0]};
							lsa_pkg::LSA_SZ_WORD:  rob_data_q[gi] <= rob_fp_q[gi] ?
								widen_sp(i_ld_data[31:0]) : {32'h0, i_ld_data[31:0]};
							lsa_pkg::LSA_SZ_DWORD: rob_data_q[gi] <= i_ld_data;
						endcase
					end
					if (head_ready_w && head_q == ENTRY_TAG) begin
						rob_busy_q[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// head pointer only advances past a finished oldest entry
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			head_q      <= '0;
			o_ret_vld   <= 1'b0;
			o_ret_tag   <= '0;
			o_ret_float <= 1'b0;
			o_ret_rd    <= '0;
			o_ret_data  <= '0;
		end else begin
			o_ret_vld   <= head_ready_w && !rob_st_q[head_q];
			o_ret_tag   <= head_q;
			o_ret_float <= rob_fp_q[head_q];
			o_ret_rd    <= rob_rd_q[head_q];
			o_ret_data  <= rob_data_q[head_q];
			if (head_ready_w) begin
				head_q <= head_q + 1'b1;
			end
		end
	end

	// register file write at retire only, so state changes in program order
	always_ff @(posedge i_clk) begin
		if (head_ready_w && !rob_st_q[head_q]) begin
			if (rob_fp_q[head_q]) begin
				float_register_file[rob_rd_q[head_q]] <= rob_data_q[head_q];
			end else begin
				general_register_file[rob_rd_q[head_q]] <= rob_data_q[head_q][31:0];
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	mis_half_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_mem_vld && o_mem_size == lsa_pkg::LSA_SZ_HALF |-> o_misaligned == o_mem_addr[0])
		else $error("half access misalignment wrong");
	mis_dword_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_mem_vld && o_mem_size == lsa_pkg::LSA_SZ_DWORD |-> o_misaligned == (|o_mem_addr[2:0]))
		else $error("double access misalignment wrong");
	mis_byte_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_misaligned |-> o_mem_vld && o_mem_size != lsa_pkg::LSA_SZ_BYTE)
		else $error("misaligned flag without sized access");
	alu_nomem_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_issue_vld && i_issue_op == lsa_pkg::LSA_OP_ALU |=> !o_mem_vld)
		else $error("alu op reached memory");
	size_op_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_issue_vld && i_issue_op == lsa_pkg::LSA_OP_LFD |=> o_mem_size == lsa_pkg::LSA_SZ_DWORD)
		else $error("double load size wrong");
	fetch_word_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_fetch_vld |-> o_fetch_addr[1:0] == lsa_pkg::FETCH_ALIGN)
		else $error("fetch address not word aligned");
	fetch_pen_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_fetch_req && fetch_wait_q == 2'h0 && i_fetch_pc[1:0] != 2'h0 |=> !o_fetch_vld ##1 o_fetch_vld)
		else $error("unaligned fetch penalty missing");
	ret_order_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_ret_vld |-> o_ret_tag == $past(head_q) && head_q == o_ret_tag + 1'b1)
		else $error("retire out of program order");
	// a single loaded into a float entry keeps its sign and has no low fraction bits
	widen_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_ld_vld && !(i_issue_vld && i_issue_tag == i_ld_tag) && rob_fp_q[i_ld_tag]
		&& rob_sz_q[i_ld_tag] == lsa_pkg::LSA_SZ_WORD
		|=> rob_data_q[$past(i_ld_tag)][28:0] == 29'h0 && rob_data_q[$past(i_ld_tag)][63] == $past(i_ld_data[31]))
		else $error("float load not double format");
	mis_c:   cover property (@(posedge i_clk) disable iff (i_srst) o_misaligned);
	fld_c:   cover property (@(posedge i_clk) disable iff (i_srst) o_ret_vld && o_ret_float);
	fetch_c: cover property (@(posedge i_clk) disable iff (i_srst) o_fetch_busy ##1 o_fetch_vld);
endmodule // lsa_core

/* core/lsa_pkg.sv */
// package of shared constants and types for the load/store operand alignment block
package lsa_pkg;
	// address and data widths
	localparam int unsigned ADDR_W    = 32;
	localparam int unsigned WORD_W    = 32;
	localparam int unsigned DWORD_W   = 64;
	localparam int unsigned REG_CNT   = 32;
	localparam int unsigned REG_IDX_W = 5;
	localparam int unsigned TAG_W     = 4;
	localparam int unsigned ROB_DEPTH = 16;

	// instruction fetch is one word, word aligned
	localparam logic [ADDR_W-1:0] INSTR_BYTES = 32'h0000_0004;
	localparam logic [1:0]        FETCH_ALIGN = 2'h0;
	// cycles lost when a fetch address is not word aligned
	localparam logic [1:0]        FETCH_PENALTY = 2'h1;

	// single- and double-precision field layout
	localparam int unsigned SP_EXP_W  = 8;
	localparam int unsigned SP_FRAC_W = 23;
	localparam int unsigned DP_EXP_W  = 11;
	localparam int unsigned DP_FRAC_W = 52;
	localparam logic [DP_EXP_W-1:0] DP_EXP_BIAS_ADJ = 11'h380;
	localparam logic [DP_EXP_W-1:0] DP_EXP_MAX      = 11'h7ff;
	localparam logic [SP_EXP_W-1:0] SP_EXP_MAX      = 8'hff;
	localparam logic [SP_EXP_W-1:0] SP_EXP_ZERO     = 8'h00;

	// operand size, fixed by the opcode
	typedef enum logic [1:0] {
		LSA_SZ_BYTE  = 2'h0,
		LSA_SZ_HALF  = 2'h1,
		LSA_SZ_WORD  = 2'h2,
		LSA_SZ_DWORD = 2'h3
	} lsa_size_t;

	// load/store opcode classes seen by this block
	typedef enum logic [3:0] {
		LSA_OP_NONE = 4'h0,
		LSA_OP_LBZ  = 4'h1,
		LSA_OP_LHZ  = 4'h2,
		LSA_OP_LWZ  = 4'h3,
		LSA_OP_STB  = 4'h4,
		LSA_OP_STH  = 4'h5,
		LSA_OP_STW  = 4'h6,
		LSA_OP_LFS  = 4'h7,
		LSA_OP_LFD  = 4'h8,
		LSA_OP_STFS = 4'h9,
		LSA_OP_STFD = 4'ha,
		LSA_OP_ALU  = 4'hb
	} lsa_op_t;
endpackage

/* tb/lsa_mem_model.sv */
// memory subsystem model: byte store plus tagged load answers after a chosen latency
`timescale 1ns/1ps
module lsa_mem_model (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	// issue and request side of the core
	input  wire logic        i_issue_vld,
	input  wire logic [3:0]  i_issue_tag,
	input  wire logic [7:0]  i_lat,
	input  wire logic        i_mem_vld,
	input  wire logic        i_mem_we,
	input  wire logic [31:0] i_mem_addr,
	input  wire logic [1:0]  i_mem_size,
	input  wire logic [63:0] i_mem_wdata,
	// load answers
	output logic             o_ld_vld,
	output logic [3:0]       o_ld_tag,
	output logic [63:0]      o_ld_data
);
	logic [7:0]  mem_q [logic [31:0]];
	logic [3:0]  tag_q;
	logic [7:0]  lat_q;
	int          cyc_q;
	int          due_q [$];
	logic [67:0] ans_q [$];

	// the request carries no tag, so keep the one issued a cycle before it
	always_ff @(posedge i_clk) begin
		if (i_issue_vld) begin
			tag_q <= i_issue_tag;
			lat_q <= i_lat;
		end
	end

	// little-endian bytes from the operand's lowest address; unwritten bytes read as ~address
	always @(posedge i_clk) begin
		logic [63:0] d;
		int          k;
		d = '0;
		k = -1;
		cyc_q = cyc_q + 1;
		if (i_mem_vld && !i_srst) begin
			for (int b = 0; b < (1 << i_mem_size); b++) begin
				if (i_mem_we)
					mem_q[i_mem_addr + 32'(b)] = i_mem_wdata[8*b +: 8];
				d[8*b +: 8] = mem_q.exists(i_mem_addr + 32'(b)) ? mem_q[i_mem_addr + 32'(b)] : ~8'(i_mem_addr + 32'(b));
			end
			if (!i_mem_we) begin
				due_q.push_back(cyc_q + int'(lat_q));
				ans_q.push_back({tag_q, d});
			end
		end
		foreach (due_q[i])
			if (k < 0 && due_q[i] <= cyc_q)
				k = i;
		// answers leave in latency order, so a slow load is overtaken by a quick one
		o_ld_vld <= k >= 0;
		{o_ld_tag, o_ld_data} <= (k >= 0) ? ans_q[k] : ~{o_ld_tag, o_ld_data};
		if (k >= 0) begin
			due_q.delete(k);
			ans_q.delete(k);
		end
		if (i_srst) begin
			due_q.delete();
			ans_q.delete();
			o_ld_vld <= 1'b0;
			{o_ld_tag, o_ld_data} <= '0;
		end
	end
endmodule // lsa_mem_model

/* tb/tb_lsa_core.sv */
// self-checking bench for the load/store operand alignment core
`timescale 1ns/1ps
module tb_lsa_core;
	// ----------------------------------------
	// stimulus, observed outputs and bookkeeping
	// ----------------------------------------
	logic             i_clk = 1'b0, i_srst = 1'b1, i_fetch_req = 1'b0, i_issue_vld = 1'b0;
	logic [31:0]      i_fetch_pc = '0, i_issue_disp = '0, i_alu_result = '0, o_fetch_addr, o_mem_addr;
	lsa_pkg::lsa_op_t i_issue_op = lsa_pkg::LSA_OP_NONE;
	lsa_pkg::lsa_size_t o_mem_size;
	logic [3:0]       i_issue_tag = '0, o_ret_tag, i_ld_tag, tag = '0;
	logic [4:0]       i_issue_base = '0, i_issue_rd = '0, o_ret_rd;
	logic [7:0]       i_lat = 8'h01;
	logic [63:0]      o_mem_wdata, i_ld_data, o_ret_data;
	logic             o_fetch_vld, o_fetch_busy, o_mem_vld, o_mem_we, o_misaligned, i_ld_vld, o_ret_vld, o_ret_float;
	logic [73:0]      ret_q [$];
	logic [99:0]      mq [$];
	int               errors = 0, total_checks = 0;

	// the rd field doubles as the store source register
	lsa_core u_lsa_core (.i_clk(i_clk), .i_srst(i_srst), .i_fetch_req(i_fetch_req), .i_fetch_pc(i_fetch_pc),
		.o_fetch_vld(o_fetch_vld), .o_fetch_addr(o_fetch_addr), .o_fetch_busy(o_fetch_busy),
		.i_issue_vld(i_issue_vld), .i_issue_op(i_issue_op), .i_issue_tag(i_issue_tag), .i_issue_base(i_issue_base),
		.i_issue_disp(i_issue_disp), .i_issue_rd(i_issue_rd), .i_issue_rs(i_issue_rd), .i_alu_result(i_alu_result),
		.o_mem_vld(o_mem_vld), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_size(o_mem_size),
		.o_mem_wdata(o_mem_wdata), .o_misaligned(o_misaligned), .i_ld_vld(i_ld_vld), .i_ld_tag(i_ld_tag),
		.i_ld_data(i_ld_data), .o_ret_vld(o_ret_vld), .o_ret_tag(o_ret_tag), .o_ret_float(o_ret_float),
		.o_ret_rd(o_ret_rd), .o_ret_data(o_ret_data));
	lsa_mem_model u_lsa_mem_model (.i_clk(i_clk), .i_srst(i_srst), .i_issue_vld(i_issue_vld),
		.i_issue_tag(i_issue_tag), .i_lat(i_lat), .i_mem_vld(o_mem_vld), .i_mem_we(o_mem_we),
		.i_mem_addr(o_mem_addr), .i_mem_size(o_mem_size), .i_mem_wdata(o_mem_wdata),
		.o_ld_vld(i_ld_vld), .o_ld_tag(i_ld_tag), .o_ld_data(i_ld_data));

	initial forever #2 i_clk = ~i_clk;

	// one-cycle pulses are captured mid-cycle, where they have settled
	always @(negedge i_clk) begin
		if (o_ret_vld)
			ret_q.push_back({o_ret_tag, o_ret_float, o_ret_rd, o_ret_data});
		if (o_mem_vld)
			mq.push_back({o_mem_we, o_mem_addr, o_mem_size, o_misaligned, o_mem_wdata});
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(string w, logic [127:0] s, logic [127:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", w, e, s);
		end
	endtask

	function automatic logic [63:0] pat(logic [31:0] a, int n);
		pat = '0;
		for (int b = 0; b < n; b++)
			pat[8*b +: 8] = ~8'(a + 32'(b));
	endfunction

	// leaves the strobe high so back-to-back issues need no gap
	task automatic issue(lsa_pkg::lsa_op_t op, logic [31:0] disp, logic [4:0] rd, logic [31:0] alu = '0,
		logic [7:0] lat = 8'h01);
		i_issue_vld = 1'b1;
		i_issue_op = op;
		i_issue_tag = tag;
		i_issue_base = 5'd1;
		i_issue_disp = disp;
		i_issue_rd = rd;
		i_alu_result = alu;
		i_lat = lat;
		tag = tag + 4'h1;
		@(posedge i_clk);
		#1;
	endtask

	task automatic drain(int n);
		i_issue_vld = 1'b0;
		for (int i = 0; i < 60 && ret_q.size() < n; i++)
			@(posedge i_clk);
		repeat (3) @(posedge i_clk);
		#1;
		check("retire count", ret_q.size(), n);
	endtask

	task automatic exp_ret(logic [3:0] t, logic f, logic [4:0] rd, logic [63:0] d, logic [63:0] m = '1);
		logic [73:0] r;
		r = ret_q.size() ? ret_q.pop_front() : 'x;
		check("retire tag", r[73:70], t);
		check("retire target", r[69:64], {f, rd});
		check("retire data", r[63:0] & m, d);
	endtask

	task automatic exp_mem(logic we, logic [31:0] a, logic [1:0] s, logic mis, logic [63:0] wd = '0,
		logic [63:0] wm = '0);
		logic [99:0] q;
		q = mq.size() ? mq.pop_front() : 'x;
		check("request kind", {q[99], q[66:65]}, {we, s});
		check("request address", q[98:67], a);
		check("misaligned flag", q[64], mis);
		check("store data", q[63:0] & wm, wd);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_alu();
		logic [3:0] t;
		t = tag;
		check("idle outputs", {o_fetch_vld, o_fetch_busy, o_mem_vld, o_misaligned, o_ret_vld}, 5'h00);
		issue(lsa_pkg::LSA_OP_ALU, '0, 5'd1, 32'h0000_1000);
		issue(lsa_pkg::LSA_OP_ALU, '0, 5'd2, 32'h8000_0001);
		issue(lsa_pkg::LSA_OP_ALU, '0, 5'd3, 32'h3fc0_0000);
		drain(3);
		exp_ret(t, 1'b0, 5'd1, 64'h0000_1000, 64'hffff_ffff);
		exp_ret(4'(t + 1), 1'b0, 5'd2, 64'h8000_0001, 64'hffff_ffff);
		exp_ret(4'(t + 2), 1'b0, 5'd3, 64'h3fc0_0000, 64'hffff_ffff);
		check("arithmetic requests", mq.size(), 0);
		$display("alu test done");
	endtask

	// every size at every offset 0..7 from an aligned base
	task automatic t_align();
		lsa_pkg::lsa_op_t ops [4];
		logic [3:0]       t;
		ops = '{lsa_pkg::LSA_OP_LBZ, lsa_pkg::LSA_OP_LHZ, lsa_pkg::LSA_OP_LWZ, lsa_pkg::LSA_OP_LFD};
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 8; k++) begin
				t = tag;
				issue(ops[s], 32'(k), 5'd4);
				drain(1);
				exp_mem(1'b0, 32'h0000_1000 + 32'(k), 2'(s), (k % (1 << s)) != 0);
				exp_ret(t, s == 3, 5'd4, pat(32'h0000_1000 + 32'(k), 1 << s), ~64'h0 >> (64 - (8 << s)));
			end
		end
		$display("alignment test done");
	endtask

	task automatic t_store();
		logic [3:0] t;
		t = tag;
		issue(lsa_pkg::LSA_OP_STW, 32'h0000_0100, 5'd2);
		issue(lsa_pkg::LSA_OP_STB, 32'h0000_0105, 5'd3);
		issue(lsa_pkg::LSA_OP_STH, 32'h0000_0106, 5'd2);
		issue(lsa_pkg::LSA_OP_LWZ, 32'h0000_0104, 5'd9);
		issue(lsa_pkg::LSA_OP_LBZ, 32'h0000_0100, 5'd10);
		issue(lsa_pkg::LSA_OP_LHZ, 32'h0000_0102, 5'd11);
		drain(3);
		exp_mem(1'b1, 32'h0000_1100, lsa_pkg::LSA_SZ_WORD, 1'b0, 64'h8000_0001, 64'hffff_ffff);
		exp_mem(1'b1, 32'h0000_1105, lsa_pkg::LSA_SZ_BYTE, 1'b0, 64'h0000_0000, 64'h0000_00ff);
		exp_mem(1'b1, 32'h0000_1106, lsa_pkg::LSA_SZ_HALF, 1'b0, 64'h0000_0001, 64'h0000_ffff);
		mq.delete();
		exp_ret(4'(t + 3), 1'b0, 5'd9, 64'h0001_00fb, 64'hffff_ffff);
		exp_ret(4'(t + 4), 1'b0, 5'd10, 64'h0000_0001, 64'hffff_ffff);
		exp_ret(4'(t + 5), 1'b0, 5'd11, 64'h0000_8000, 64'hffff_ffff);
		$display("store test done");
	endtask

	task automatic t_float();
		logic [3:0] t;
		t = tag;
		issue(lsa_pkg::LSA_OP_STW, 32'h0000_0200, 5'd3);
		issue(lsa_pkg::LSA_OP_STW, 32'h0000_0204, 5'd2);
		issue(lsa_pkg::LSA_OP_LFS, 32'h0000_0200, 5'd5);
		issue(lsa_pkg::LSA_OP_LFS, 32'h0000_0204, 5'd6);
		drain(2);
		exp_ret(4'(t + 2), 1'b1, 5'd5, 64'h3ff8_0000_0000_0000);
		exp_ret(4'(t + 3), 1'b1, 5'd6, 64'h8000_0000_0000_0000);
		mq.delete();
		t = tag;
		issue(lsa_pkg::LSA_OP_STFD, 32'h0000_0208, 5'd5);
		issue(lsa_pkg::LSA_OP_LFD, 32'h0000_0208, 5'd7);
		// float word store narrows the double back to single
		issue(lsa_pkg::LSA_OP_STFS, 32'h0000_020c, 5'd5);
		issue(lsa_pkg::LSA_OP_LFS, 32'h0000_020c, 5'd8);
		drain(2);
		exp_mem(1'b1, 32'h0000_1208, lsa_pkg::LSA_SZ_DWORD, 1'b0, 64'h3ff8_0000_0000_0000, '1);
		exp_mem(1'b0, 32'h0000_1208, lsa_pkg::LSA_SZ_DWORD, 1'b0);
		exp_mem(1'b1, 32'h0000_120c, lsa_pkg::LSA_SZ_WORD, 1'b0, 64'h0000_0000_3fc0_0000, '1);
		exp_ret(4'(t + 1), 1'b1, 5'd7, 64'h3ff8_0000_0000_0000);
		exp_ret(4'(t + 3), 1'b1, 5'd8, 64'h3ff8_0000_0000_0000);
		mq.delete();
		$display("float test done");
	endtask

	// loads answered out of order must still retire in issue order
	task automatic t_order();
		logic [3:0] t;
		t = tag;
		issue(lsa_pkg::LSA_OP_LWZ, 32'h0000_0100, 5'd12, '0, 8'd9);
		issue(lsa_pkg::LSA_OP_LWZ, 32'h0000_0104, 5'd13, '0, 8'd1);
		issue(lsa_pkg::LSA_OP_LBZ, 32'h0000_0200, 5'd14, '0, 8'd4);
		// an empty slot retires silently but still takes its place in order
		issue(lsa_pkg::LSA_OP_NONE, '0, 5'd16);
		issue(lsa_pkg::LSA_OP_ALU, '0, 5'd15, 32'h0000_5a5a);
		drain(4);
		mq.delete();
		exp_ret(t, 1'b0, 5'd12, 64'h8000_0001, 64'hffff_ffff);
		exp_ret(4'(t + 1), 1'b0, 5'd13, 64'h0001_00fb, 64'hffff_ffff);
		exp_ret(4'(t + 2), 1'b0, 5'd14, 64'h0000_0000, 64'hffff_ffff);
		exp_ret(4'(t + 4), 1'b0, 5'd15, 64'h0000_5a5a, 64'hffff_ffff);
		$display("order test done");
	endtask

	// an unaligned pc costs one busy cycle, and a request during it is dropped
	task automatic t_fetch();
		i_fetch_req = 1'b1;
		i_fetch_pc = 32'h0000_0100;
		@(posedge i_clk);
		#1;
		check("aligned fetch", {o_fetch_vld, o_fetch_busy, o_fetch_addr}, {2'b10, 32'h0000_0100});
		i_fetch_pc = 32'h0000_0106;
		@(posedge i_clk);
		#1;
		check("fetch penalty", {o_fetch_vld, o_fetch_busy}, 2'b01);
		@(posedge i_clk);
		#1;
		i_fetch_req = 1'b0;
		check("unaligned fetch", {o_fetch_vld, o_fetch_busy, o_fetch_addr}, {2'b10, 32'h0000_0104});
		@(posedge i_clk);
		#1;
		check("dropped fetch", {o_fetch_vld, o_fetch_busy}, 2'b00);
		$display("fetch test done");
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// the whole run needs about 350 cycles
	initial begin
		#40000;
		errors++;
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge i_clk);
		#1;
		i_srst = 1'b0;
		t_alu();
		t_align();
		t_store();
		t_float();
		t_order();
		t_fetch();
		give_verdict();
	end
endmodule // tb_lsa_core
